/* File: rtl/jpi_defines.vh */
// Purpose: constants for the test-port instruction unit
// Assumes: 8-bit instruction register, 16-bit user signature
// Notes: none
// How it works
// (R1) Leave-programming instruction clears programming mode
// (R2) Test-Logic-Reset also clears programming mode
// (R3) Signature read loads shifter, selects it
// (R4) Signature write stores shifter into memory
// (R5) Host enters programming mode before signature write
// (R6) Signature write forces outputs tri-state
// (R7) Erase-completion clears flag, blocks power sequence
// (R8) Set-completion sets flag, allows power sequence
// (R9) Reset instruction resets array sequence, macrocells
// (R10) Post-reset state equals power-up state
// (R11) Readback loads column data, increments address
// (R12) Forced condition tri-states all digital, FET outputs
// (R13) Host erases bits before programming them
// (R14) Signature read 0x17, signature write 0x1A
// (R15) Erase completion 0x24, set completion 0x2F
// (R16) Enter programming 0x15 forces tri-state; leave 0x1E
// (R17) Reset 0x22, readback autoinc 0x2A
// (R18) Standard TAP, instructions act at Update-IR
`ifndef JPI_DEFINES_VH
`define JPI_DEFINES_VH
`define JPI_IR_W 8
`define JPI_SIG_W 16
`define JPI_COL_W 81
`define JPI_ADDR_W 6
`define JPI_I_BYPASS 8'hFF
`define JPI_I_SIG_READ 8'h17
`define JPI_I_SIG_WRITE 8'h1A
`define JPI_I_DONE_ERASE 8'h24
`define JPI_I_DONE_SET 8'h2F
`define JPI_I_PROG_ENTER 8'h15
`define JPI_I_PROG_LEAVE 8'h1E
`define JPI_I_RESET 8'h22
`define JPI_I_READBACK 8'h2A
`define JPI_I_TRISTATE 8'h18
`define JPI_IR_CAPTURE 8'h01
`define JPI_DONE_RST 1'b0
`endif

/* File: rtl/jpi_pin_sync.v */
// Purpose: three-stage pin synchroniser with agreement check
// Assumes: input is asynchronous to the system clock
// Notes: first stage read only by the second
`timescale 1ns/1ps
module jpi_pin_sync (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire pin_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end
    else if (ce_i)
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      // Counts a change only once two late stages agree
      if (s2 == s3)
        level_o <= s3;
    end
  end
endmodule

/* File: rtl/jpi_tap_fsm.v */
// Purpose: standard test-port state machine, one-hot
// Assumes: advanced once per rising test-clock edge
// Notes: outputs decoded from the state register
`timescale 1ns/1ps
module jpi_tap_fsm (
  input wire clk_i,
  input wire rst_b_i,
  input wire adv_i,
  input wire tms_i,
  output wire tlr_o,
  output wire cap_dr_o,
  output wire sh_dr_o,
  output wire upd_dr_o,
  output wire cap_ir_o,
  output wire sh_ir_o,
  output wire upd_ir_o,
  output wire rti_o
);
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PD = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PI = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;
  reg [15:0] state;
  reg [15:0] next_state;
  always @*
  begin
    case (state)
      S_TLR: next_state = tms_i ? S_TLR : S_RTI;
      S_RTI: next_state = tms_i ? S_SDR : S_RTI;
      S_SDR: next_state = tms_i ? S_SIR : S_CDR;
      S_CDR: next_state = tms_i ? S_E1D : S_SHD;
      S_SHD: next_state = tms_i ? S_E1D : S_SHD;
      S_E1D: next_state = tms_i ? S_UDR : S_PD;
      S_PD: next_state = tms_i ? S_E2D : S_PD;
      S_E2D: next_state = tms_i ? S_UDR : S_SHD;
      S_UDR: next_state = tms_i ? S_SDR : S_RTI;
      S_SIR: next_state = tms_i ? S_TLR : S_CIR;
      S_CIR: next_state = tms_i ? S_E1I : S_SHI;
      S_SHI: next_state = tms_i ? S_E1I : S_SHI;
      S_E1I: next_state = tms_i ? S_UIR : S_PI;
      S_PI: next_state = tms_i ? S_E2I : S_PI;
      S_E2I: next_state = tms_i ? S_UIR : S_SHI;
      S_UIR: next_state = tms_i ? S_SDR : S_RTI;
      default: next_state = S_TLR;
    endcase
  end
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state <= S_TLR;
    else if (adv_i)
      state <= next_state;
  end
  assign tlr_o = state[0];
  assign rti_o = state[1];
  assign cap_dr_o = state[3];
  assign sh_dr_o = state[4];
  assign upd_dr_o = state[8];
  assign cap_ir_o = state[10];
  assign sh_ir_o = state[11];
  assign upd_ir_o = state[15];
endmodule

/* File: rtl/jpi_instr_unit.v */
// Purpose: test-port instruction unit for programming and control
// Assumes: TCK, TMS, TDI are pins sampled by the system clock
// Notes: TDO changes on the falling TCK edge seen by the sampler
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "jpi_defines.vh"
module jpi_instr_unit #(
  parameter SIG_W = `JPI_SIG_W,
  parameter COL_W = `JPI_COL_W,
  parameter ADDR_W = `JPI_ADDR_W
) (
  input wire SYS_CLK_I,
  input wire RST_B_I,
  input wire CE_I,
  input wire TCK_I,
  input wire TMS_I,
  input wire TDI_I,
  input wire [COL_W-1:0] ARRAY_COL_DATA_I,
  input wire [SIG_W-1:0] SIG_NV_DATA_I,
  output reg TDO_O,
  output reg TDO_OE_O,
  output reg [SIG_W-1:0] SIG_NV_WDATA_O,
  output reg SIG_NV_WRITE_O,
  output reg [ADDR_W-1:0] ARRAY_COL_ADDR_O,
  output reg PROG_MODE_O,
  output reg DONE_O,
  output reg SEQ_ENABLE_O,
  output reg LOGIC_RESET_O,
  output reg FORCED_TRISTATE_OUTPUTS_O
);

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and test-clock edge detection

  wire tck_s;
  wire tms_s;
  wire tdi_s;
  reg tck_d;

  jpi_pin_sync u_sync_tck (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .pin_i(TCK_I),
    .level_o(tck_s)
  );
  jpi_pin_sync u_sync_tms (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .pin_i(TMS_I),
    .level_o(tms_s)
  );
  jpi_pin_sync u_sync_tdi (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .pin_i(TDI_I),
    .level_o(tdi_s)
  );

  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      tck_d <= 1'b0;
    else if (CE_I)
      tck_d <= tck_s;
  end

  wire tck_rise = CE_I & tck_s & ~tck_d;
  wire tck_fall = CE_I & ~tck_s & tck_d;

  ////////////////////////////////////////////////////////////////////////
  // Controller

  wire st_tlr;
  wire st_cdr;
  wire st_sdr;
  wire st_udr;
  wire st_cir;
  wire st_sir;
  wire st_uir;
  wire st_rti;

  jpi_tap_fsm u_tap (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .adv_i(tck_rise),
    .tms_i(tms_s),
    .tlr_o(st_tlr),
    .cap_dr_o(st_cdr),
    .sh_dr_o(st_sdr),
    .upd_dr_o(st_udr),
    .cap_ir_o(st_cir),
    .sh_ir_o(st_sir),
    .upd_ir_o(st_uir),
    .rti_o(st_rti)
  );

  ////////////////////////////////////////////////////////////////////////
  // Instruction register

  // Instructions that force every output pin to tri-state
  function forces_tristate;
    input [`JPI_IR_W-1:0] code;
    begin
      forces_tristate = (code == `JPI_I_TRISTATE) ||
        (code == `JPI_I_PROG_ENTER) || // [R16]
        (code == `JPI_I_SIG_WRITE); // [R6]
    end
  endfunction

  reg [`JPI_IR_W-1:0] ir_shift;
  reg [`JPI_IR_W-1:0] ir;
  reg uir_seen;

  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ir_shift <= `JPI_IR_CAPTURE;
      ir <= `JPI_I_BYPASS;
    end
    else if (tck_rise)
    begin
      if (st_tlr)
        ir <= `JPI_I_BYPASS;
      else if (st_cir)
        ir_shift <= `JPI_IR_CAPTURE;
      else if (st_sir)
        ir_shift <= {tdi_s, ir_shift[`JPI_IR_W-1:1]};
      else if (st_uir)
        ir <= ir_shift; // [R18]
    end
  end

  // One-cycle pulse on the edge that leaves Update-IR, so each
  // instruction fires exactly once
  wire ir_fire = tck_rise & st_uir;

  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      uir_seen <= 1'b0;
    else if (CE_I)
      uir_seen <= ir_fire;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data registers

  reg [SIG_W-1:0] sig_shift;
  reg [COL_W-1:0] col_shift;
  reg bypass_bit;
  reg readback_pending;
  wire sel_sig = (ir == `JPI_I_SIG_READ) || (ir == `JPI_I_SIG_WRITE);
  wire sel_col = (ir == `JPI_I_READBACK);

  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      sig_shift <= {SIG_W{1'b0}};
      col_shift <= {COL_W{1'b0}};
      bypass_bit <= 1'b0;
    end
    else if (uir_seen && ir == `JPI_I_SIG_READ)
      sig_shift <= SIG_NV_DATA_I; // [R3]
    else if (tck_rise)
    begin
      if (st_cdr)
      begin
        bypass_bit <= 1'b0;
        if (sel_col)
          col_shift <= ARRAY_COL_DATA_I; // [R11]
      end
      else if (st_sdr)
      begin
        bypass_bit <= tdi_s;
        if (sel_sig)
          sig_shift <= {tdi_s, sig_shift[SIG_W-1:1]}; // [R3]
        if (sel_col)
          col_shift <= {tdi_s, col_shift[COL_W-1:1]}; // [R11]
      end
    end
  end

  // Address advances once the column has been read out
  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ARRAY_COL_ADDR_O <= {ADDR_W{1'b0}};
      readback_pending <= 1'b0;
    end
    else if (tck_rise)
    begin
      if (st_cdr && sel_col)
        readback_pending <= 1'b1;
      else if (st_udr && readback_pending)
      begin
        readback_pending <= 1'b0;
        ARRAY_COL_ADDR_O <= ARRAY_COL_ADDR_O + 1'b1; // [R11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Test data out, driven only while shifting

  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      TDO_O <= 1'b0;
      TDO_OE_O <= 1'b0;
    end
    else if (tck_fall)
    begin
      TDO_OE_O <= st_sdr | st_sir;
      if (st_sir)
        TDO_O <= ir_shift[0];
      else if (sel_sig)
        TDO_O <= sig_shift[0];
      else if (sel_col)
        TDO_O <= col_shift[0];
      else
        TDO_O <= bypass_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction actions

  reg next_prog;
  reg next_done;
  reg next_store;
  reg next_lrst;

  // Decoded one cycle after Update-IR, once the new code has settled
  always @*
  begin
    next_prog = PROG_MODE_O;
    next_done = DONE_O;
    next_store = 1'b0;
    next_lrst = 1'b0;
    if (st_tlr)
      next_prog = 1'b0; // [R2]
    else if (uir_seen)
    begin
      case (ir)
        `JPI_I_PROG_ENTER: next_prog = 1'b1; // [R16]
        `JPI_I_PROG_LEAVE: next_prog = 1'b0; // [R1]
        `JPI_I_DONE_ERASE: next_done = 1'b0; // [R7] [R15]
        `JPI_I_DONE_SET: next_done = 1'b1; // [R8] [R15]
        `JPI_I_RESET: next_lrst = 1'b1; // [R9] [R10] [R17]
        // Writes only in programming mode; the host keeps order
        `JPI_I_SIG_WRITE: next_store = PROG_MODE_O; // [R4] [R5] [R14]
        default: next_prog = PROG_MODE_O;
      endcase
    end
  end

  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      PROG_MODE_O <= 1'b0;
      DONE_O <= `JPI_DONE_RST;
      SIG_NV_WRITE_O <= 1'b0;
      SIG_NV_WDATA_O <= {SIG_W{1'b0}};
      LOGIC_RESET_O <= 1'b0;
    end
    else if (CE_I)
    begin
      PROG_MODE_O <= next_prog;
      DONE_O <= next_done;
      SIG_NV_WRITE_O <= next_store; // [R4]
      LOGIC_RESET_O <= next_lrst;
      if (next_store)
        SIG_NV_WDATA_O <= sig_shift; // [R4]
    end
  end

  // Sequence runs only with the flag set and no array reset pending;
  // built from the next flag value so it never outlives the flag
  always @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      SEQ_ENABLE_O <= 1'b0;
      FORCED_TRISTATE_OUTPUTS_O <= 1'b0;
    end
    else if (CE_I)
    begin
      SEQ_ENABLE_O <= next_done & ~next_lrst; // [R7] [R8]
      FORCED_TRISTATE_OUTPUTS_O <= forces_tristate(ir); // [R6] [R12]
    end
  end

endmodule

/* File: verif/jpi_checker.sv */
// Purpose: port assertions for the instruction unit
// Assumes: one clock domain, async active-low reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module jpi_checker #(
  parameter ADDR_W = 6
) (
  input wire SYS_CLK_I,
  input wire RST_B_I,
  input wire SIG_NV_WRITE_O,
  input wire [ADDR_W-1:0] ARRAY_COL_ADDR_O,
  input wire PROG_MODE_O,
  input wire DONE_O,
  input wire SEQ_ENABLE_O,
  input wire LOGIC_RESET_O,
  input wire FORCED_TRISTATE_OUTPUTS_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  chk_write_in_prog: assert property (SIG_NV_WRITE_O |-> PROG_MODE_O)
    else $error("store outside programming mode");
  chk_write_pulse: assert property ($rose(SIG_NV_WRITE_O) |->
    s_pulse(SIG_NV_WRITE_O))
    else $error("store pulse too long");
  chk_write_hiz: assert property
    (SIG_NV_WRITE_O |-> FORCED_TRISTATE_OUTPUTS_O)
    else $error("store without forced tri-state");
  chk_reset_pulse: assert property ($rose(LOGIC_RESET_O) |->
    s_pulse(LOGIC_RESET_O))
    else $error("reset pulse too long");
  chk_seq_needs_done: assert property (SEQ_ENABLE_O |-> DONE_O)
    else $error("sequence allowed without flag");
  chk_done_allows: assert property ($rose(DONE_O) |->
    ##[0:2] SEQ_ENABLE_O)
    else $error("sequence not allowed after flag set");
  chk_addr_step: assert property ($changed(ARRAY_COL_ADDR_O) |->
    ARRAY_COL_ADDR_O == $past(ARRAY_COL_ADDR_O) + 1'b1)
    else $error("column address jumped");
  chk_prog_hiz: assert property ($rose(PROG_MODE_O) |->
    FORCED_TRISTATE_OUTPUTS_O)
    else $error("programming mode without tri-state");
endmodule

bind jpi_instr_unit jpi_checker #(.ADDR_W(ADDR_W)) i_jpi_checker (
  .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
  .SIG_NV_WRITE_O(SIG_NV_WRITE_O), .ARRAY_COL_ADDR_O(ARRAY_COL_ADDR_O),
  .PROG_MODE_O(PROG_MODE_O), .DONE_O(DONE_O),
  .SEQ_ENABLE_O(SEQ_ENABLE_O), .LOGIC_RESET_O(LOGIC_RESET_O),
  .FORCED_TRISTATE_OUTPUTS_O(FORCED_TRISTATE_OUTPUTS_O));

/* File: verif/jpi_host_model.sv */
// Purpose: boundary-scan host driving the test port
// Assumes: test clock half period of ten system clocks
// Notes: test clock stands low between scans
`timescale 1ns/1ps
module jpi_host_model (
  input wire clk_i,
  input wire tdo_i,
  output reg tck_o,
  output reg tms_o,
  output reg tdi_o
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // TMS and TDI move at the falling half, so they are stable at rise
  task cyc(input logic tms, input logic tdi, output logic tdo);
    begin
      @(posedge clk_i);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (9) @(posedge clk_i);
      tck_o <= 1'b1;
      tdo = tdo_i;
      repeat (10) @(posedge clk_i);
      tck_o <= 1'b0;
    end
  endtask
  task moves(input logic [7:0] pat, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      cyc(pat[i], 1'b0, d);
  endtask
  task shift(input int n, input logic [80:0] din, output logic [80:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      cyc(i == n - 1, din[i], dout[i]);
  endtask
  task tlr;
    moves(8'h1F, 6);
  endtask
  task load_ir(input logic [7:0] code);
    logic [80:0] d;
    // Leading TMS low leaves Test-Logic-Reset and is harmless from idle
    moves(8'h06, 5);
    shift(8, {73'h0, code}, d);
    moves(8'h01, 2);
  endtask
  task scan_dr(input int n, input logic [80:0] din, output logic [80:0] dout);
    moves(8'h01, 3);
    shift(n, din, dout);
    moves(8'h01, 2);
  endtask
endmodule

/* File: verif/test_jtag_program_instruction_unit.sv */
// Purpose: self-checking bench for the instruction unit
// Assumes: host model drives the test port pins
// Notes: model state kept in integers beside the design
`timescale 1ns/1ps
module test_jtag_program_instruction_unit;
  logic sys_clk = 0, rst_b = 0, tck, tms, tdi, tdo, oe, wr, prog, done;
  logic seq, lrst, fto, ce = 1'b1;
  int n_oe = 0;
  logic [80:0] col = '0, din, dout;
  logic [15:0] sig = '0, wdata, got;
  logic [5:0] addr;
  logic [31:0] seed = 32'h127C05A3;
  int failures = 0, total_checks = 0, cycles = 0, n_wr = 0, n_rst = 0;
  int m_prog = 0, m_done = 0, m_addr = 0, m_wr = 0, m_rst = 0;
  always #2 sys_clk = ~sys_clk;
  jpi_host_model i_jpi_host_model (.clk_i(sys_clk), .tdo_i(tdo),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  jpi_instr_unit i_jpi_instr_unit (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b),
    .CE_I(ce), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
    .ARRAY_COL_DATA_I(col), .SIG_NV_DATA_I(sig), .TDO_O(tdo),
    .TDO_OE_O(oe), .SIG_NV_WDATA_O(wdata), .SIG_NV_WRITE_O(wr),
    .ARRAY_COL_ADDR_O(addr), .PROG_MODE_O(prog), .DONE_O(done),
    .SEQ_ENABLE_O(seq), .LOGIC_RESET_O(lrst),
    .FORCED_TRISTATE_OUTPUTS_O(fto));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [80:0] seen, input logic [80:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (wr === 1'b1)
    begin
      n_wr <= n_wr + 1;
      got <= wdata;
    end
    if (lrst === 1'b1)
      n_rst <= n_rst + 1;
    if (oe === 1'b1)
      n_oe <= n_oe + 1;
    if (cycles == 30000)
    begin
      failures++;
      close_out;
    end
  end
  task ir(input logic [7:0] c);
    i_jpi_host_model.load_ir(c);
    case (c)
      8'h15: m_prog = 1;
      8'h1E: m_prog = 0;
      8'h1A: m_wr += m_prog;
      8'h2F: m_done = 1;
      8'h24: m_done = 0;
      8'h22: m_rst++;
      default: ;
    endcase
    repeat (4) @(negedge sys_clk);
    chk(prog, m_prog);
    chk({done, seq}, {2{m_done[0]}});
    chk(fto, c == 8'h15 || c == 8'h1A || c == 8'h18);
    chk(n_wr, m_wr);
    chk(n_rst, m_rst);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk({prog, done, addr}, 0);
    ir(8'h1A);
    ir(8'h15);
    sig <= 16'(rnd());
    din = {49'h0, rnd()};
    ir(8'h17);
    i_jpi_host_model.scan_dr(16, din, dout);
    chk(dout[15:0], sig);
    ir(8'h1A);
    chk(got, din[15:0]);
    ir(8'h1E);
    ir(8'h1A);
    ir(8'h15);
    i_jpi_host_model.tlr();
    m_prog = 0;
    @(negedge sys_clk);
    chk(prog, 0);
    ir(8'h24);
    ir(8'h2F);
    ir(8'h24);
    ir(8'h18);
    ir(8'h2A);
    repeat (3)
    begin
      col <= {rnd(), rnd(), 17'(rnd())};
      i_jpi_host_model.scan_dr(81, {rnd(), rnd(), 17'(rnd())}, dout);
      m_addr++;
      @(negedge sys_clk);
      chk(dout, col);
      chk(addr, m_addr);
    end
    ir(8'h22);
    ir(8'hFF);
    din = {49'h0, rnd()};
    i_jpi_host_model.scan_dr(4, din, dout);
    chk(dout[3:0], {din[2:0], 1'b0});
    chk(oe, 0);
    chk(n_oe != 0, 1);
    ir(8'h15);
    @(posedge sys_clk);
    ce <= 1'b0;
    i_jpi_host_model.load_ir(8'h1E);
    repeat (4) @(negedge sys_clk);
    chk(prog, 1);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    ce <= 1'b1;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk({prog, addr, fto}, 0);
    close_out;
  end
endmodule
